// file: design/quadrature_position_decoder.sv
`timescale 1ns/1ps
`include "qpd_map.svh"
// Function
// RULE1: control bit picks counting first-phase edges only or both phases.
// RULE2: control bit picks index reset of position or free relative counting.
// RULE3: control bit picks quadrature decoding or step clock plus direction.
// RULE4: control bit swaps the two phase inputs ahead of all decoding.
// RULE5: programmable maximum position bounds the position counter.
// RULE6: index reset while moving reverse loads maximum position, not zero.
// RULE7: readable direction bit keeps the last detected direction.
// RULE8: error flag sets when both phases change in one sample; the code flags this in quadrature mode only.
// RULE9: four sticky interrupt sources, each cleared by writing its bit.
// RULE10: per-source enables; only enabled pending sources drive irq.
// RULE11: raw and masked interrupt status both readable.
// RULE12: module enable starts decoding; clearing it stops all decoding.
// RULE13: software configures fully before setting the module enable.
// RULE14: velocity counts predivided pulses over period clocks, saves, clears.
// RULE15: velocity capture runs only while position decoding is enabled.
// RULE16: software position write replaces the count; counting continues from it.
// RULE17: forward past maximum wraps to zero; reverse below zero wraps to maximum.
// RULE18: inputs synchronised before edge detection; one count per decoded edge.
module quadrature_position_decoder (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write not read
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic phase_input_first, // encoder channel one
	input wire logic phase_input_second, // encoder channel two
	input wire logic index_input, // encoder index
	output logic irq // level interrupt
);
	qpd_pkg::cfg_t cfg_q, cfg_d;
	qpd_pkg::irq_t ris_q, ris_d, inten_q, inten_d, ev;
	qpd_pkg::ahb_req_t req_q, req_d;
	qpd_pkg::rd_state_t rd_q, rd_d;
	logic [2:0] syn1_q, syn2_q, smp_q, cur;
	logic [31:0] pos_q, pos_d, max_q, max_d, per_q, per_d, tmr_q, tmr_d;
	logic [31:0] cnt_q, cnt_d, spd_q, spd_d, hrdata_q, hrdata_d, rsel;
	logic [6:0] pdv_q, pdv_d;
	logic rev_q, rev_d, err_q, err_d;
	logic ca, cb, step, fwd, err_ev, idx_rise, accept, pos_wr, vel_run, vpulse;
	logic [3:0] clr;

	// one position step with wrap at both ends
	function automatic logic [31:0] pos_step(input logic [31:0] p, input logic [31:0] mx, input logic up);
		if (up) begin
			pos_step = (p == mx) ? 32'h00000000 : p + 32'h00000001;
		end else begin
			pos_step = (p == 32'h00000000) ? mx : p - 32'h00000001;
		end
	endfunction

	// pins pass two flops; swap applied after the synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			syn1_q <= 3'h0;
			syn2_q <= 3'h0;
			smp_q <= 3'h0;
		end else begin
			syn1_q <= {index_input, phase_input_second, phase_input_first}; // [RULE18]
			syn2_q <= syn1_q;
			smp_q <= cur;
		end
	end
	assign cur = cfg_q.swap ? {syn2_q[2], syn2_q[0], syn2_q[1]} : syn2_q; // [RULE4]

	// edge decode; in quadrature mode a simultaneous change of both phases is an error, not a count
	always_comb begin
		ca = cur[0] ^ smp_q[0];
		cb = cur[1] ^ smp_q[1];
		idx_rise = cfg_q.enable & cur[2] & ~smp_q[2];
		if (cfg_q.clk_dir) begin
			err_ev = 1'b0;
			step = cfg_q.enable & cur[0] & ~smp_q[0]; // [RULE3]
			fwd = ~cur[1];
		end else begin
			err_ev = cfg_q.enable & ca & cb; // [RULE8]
			step = cfg_q.enable & ~(ca & cb) & (cfg_q.both_edges ? (ca | cb) : ca); // [RULE1] [RULE12]
			fwd = ca ? (cur[0] ^ cur[1]) : (cur[0] ~^ cur[1]);
		end
	end

	// bus side decode
	assign accept = hsel & htrans[1] & hready;
	assign pos_wr = req_q.wr && (req_q.addr == `QPD_POS_OFS);
	assign vel_run = cfg_q.enable & cfg_q.vel_en; // [RULE15]
	assign vpulse = vel_run & step & (pdv_q == (7'h7F >> (3'd7 - cfg_q.prediv)));

	// position, direction, velocity and interrupt next state
	always_comb begin
		pos_d = pos_q;
		rev_d = rev_q;
		err_d = err_q;
		pdv_d = pdv_q;
		cnt_d = cnt_q;
		spd_d = spd_q;
		tmr_d = tmr_q;
		ev = '0;
		clr = 4'h0;
		// software write wins over index and steps
		if (pos_wr) begin
			pos_d = hwdata; // [RULE16]
		end else if (idx_rise && cfg_q.idx_reset) begin
			pos_d = rev_q ? max_q : 32'h00000000; // [RULE2] [RULE6]
		end else if (step) begin
			pos_d = pos_step(pos_q, max_q, fwd); // [RULE5] [RULE17] [RULE18]
		end
		if (step) begin
			rev_d = ~fwd; // [RULE7]
			ev.dir = rev_q == fwd;
		end
		ev.error = err_ev;
		ev.index = idx_rise;
		// predivider then accumulator; timer counts period clocks
		if (vel_run) begin
			if (step) begin
				pdv_d = vpulse ? 7'h00 : pdv_q + 7'h01;
			end
			if (tmr_q == 32'h00000000) begin
				spd_d = cnt_q + {31'h00000000, vpulse}; // [RULE14]
				cnt_d = 32'h00000000;
				tmr_d = per_q - 32'h00000001;
				ev.timer = 1'b1;
			end else begin
				cnt_d = cnt_q + {31'h00000000, vpulse};
				tmr_d = tmr_q - 32'h00000001;
			end
		end
		if (req_q.wr && (req_q.addr == `QPD_RIS_OFS || req_q.addr == `QPD_ISC_OFS)) begin
			clr = hwdata[3:0];
		end
		// set wins over a same-cycle clear
		ris_d = (ris_q & ~clr) | ev; // [RULE9]
		if (req_q.wr && req_q.addr == `QPD_STAT_OFS && hwdata[`QPD_STAT_ERR]) begin
			err_d = 1'b0;
		end
		if (err_ev) begin
			err_d = 1'b1; // [RULE8]
		end
	end

	// core registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_q <= 32'h00000000;
			rev_q <= 1'b0;
			err_q <= 1'b0;
			pdv_q <= 7'h00;
			cnt_q <= 32'h00000000;
			spd_q <= 32'h00000000;
			tmr_q <= `QPD_PERIOD_RST;
			ris_q <= '0;
		end else begin
			pos_q <= pos_d;
			rev_q <= rev_d;
			err_q <= err_d;
			pdv_q <= pdv_d;
			cnt_q <= cnt_d;
			spd_q <= spd_d;
			tmr_q <= tmr_d;
			ris_q <= ris_d;
		end
	end

	// read mux over the latched address
	always_comb begin
		if (req_q.addr == `QPD_CTRL_OFS) begin
			rsel = {23'h000000, cfg_q};
		end else if (req_q.addr == `QPD_STAT_OFS) begin
			rsel = {30'h00000000, rev_q, err_q}; // [RULE7]
		end else if (req_q.addr == `QPD_POS_OFS) begin
			rsel = pos_q;
		end else if (req_q.addr == `QPD_MAXPOS_OFS) begin
			rsel = max_q;
		end else if (req_q.addr == `QPD_PERIOD_OFS) begin
			rsel = per_q;
		end else if (req_q.addr == `QPD_TIMER_OFS) begin
			rsel = tmr_q;
		end else if (req_q.addr == `QPD_COUNT_OFS) begin
			rsel = cnt_q;
		end else if (req_q.addr == `QPD_SPEED_OFS) begin
			rsel = spd_q;
		end else if (req_q.addr == `QPD_INTEN_OFS) begin
			rsel = {28'h0000000, inten_q};
		end else if (req_q.addr == `QPD_RIS_OFS) begin
			rsel = {28'h0000000, ris_q}; // [RULE11]
		end else if (req_q.addr == `QPD_ISC_OFS) begin
			rsel = {28'h0000000, ris_q & inten_q}; // [RULE11]
		end else begin
			rsel = 32'h00000000;
		end
	end

	// bus next state; reads take one wait state so they see the prior write
	always_comb begin
		req_d = req_q;
		rd_d = rd_q;
		hrdata_d = hrdata_q;
		cfg_d = cfg_q;
		max_d = max_q;
		per_d = per_q;
		inten_d = inten_q;
		hreadyout = (rd_q != qpd_pkg::RD_CAPT);
		if (req_q.wr) begin
			if (req_q.addr == `QPD_CTRL_OFS) begin
				cfg_d = qpd_pkg::cfg_t'(hwdata[`QPD_CTRL_PDIV_HI:`QPD_CTRL_EN]); // [RULE12]
			end else if (req_q.addr == `QPD_MAXPOS_OFS) begin
				max_d = hwdata; // [RULE5]
			end else if (req_q.addr == `QPD_PERIOD_OFS) begin
				per_d = hwdata;
			end else if (req_q.addr == `QPD_INTEN_OFS) begin
				inten_d = qpd_pkg::irq_t'(hwdata[3:0]); // [RULE10]
			end
		end
		case (rd_q)
			qpd_pkg::RD_CAPT: begin
				hrdata_d = rsel;
				rd_d = qpd_pkg::RD_SHOW;
			end
			default: begin
				rd_d = qpd_pkg::RD_IDLE;
			end
		endcase
		if (hreadyout) begin
			req_d.wr = accept & hwrite;
			if (accept) begin
				req_d.addr = haddr[7:0];
				rd_d = hwrite ? qpd_pkg::RD_IDLE : qpd_pkg::RD_CAPT;
			end
		end
	end

	// bus registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
			rd_q <= qpd_pkg::RD_IDLE;
			hrdata_q <= 32'h00000000;
			cfg_q <= qpd_pkg::cfg_t'(`QPD_CTRL_RST);
			max_q <= `QPD_MAXPOS_RST;
			per_q <= `QPD_PERIOD_RST;
			inten_q <= '0;
		end else begin
			req_q <= req_d;
			rd_q <= rd_d;
			hrdata_q <= hrdata_d;
			cfg_q <= cfg_d;
			max_q <= max_d;
			per_q <= per_d;
			inten_q <= inten_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hresp = 1'b0;
	assign irq = |(ris_q & inten_q); // [RULE10]

	default clocking cb_main @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_wrap_fwd_zero: assert property (step && fwd && !pos_wr && !idx_rise && pos_q == max_q |=> pos_q == 0) // [RULE17]
		else $error("forward wrap did not reach zero");
	a_wrap_rev_max: assert property (step && !fwd && !pos_wr && !idx_rise && pos_q == 0 |=> pos_q == $past(max_q)) // [RULE17]
		else $error("reverse wrap did not reach maximum");
	a_index_rev_load: assert property (idx_rise && cfg_q.idx_reset && rev_q && !pos_wr |=> pos_q == $past(max_q)) // [RULE6]
		else $error("reverse index did not load maximum");
	a_pos_write_load: assert property (pos_wr |=> pos_q == $past(hwdata)) // [RULE16]
		else $error("position write not taken");
	a_error_flag_set: assert property (cfg_q.enable && !cfg_q.clk_dir && ca && cb |=> err_q && ris_q.error) // [RULE8]
		else $error("phase error not flagged");
	a_disabled_pos_hold: assert property (!cfg_q.enable && !pos_wr |=> $stable(pos_q)) // [RULE12]
		else $error("position moved while disabled");
	a_velocity_gated: assert property (!cfg_q.enable |=> $stable(cnt_q) && $stable(tmr_q)) // [RULE15]
		else $error("velocity ran while disabled");
	a_dir_retained: assert property (!step |=> rev_q == $past(rev_q)) // [RULE7]
		else $error("direction changed without a step");
	a_ris_sticky_hold: assert property (ris_q.index && !(req_q.wr && req_q.addr == `QPD_RIS_OFS) && // [RULE9]
		!(req_q.wr && req_q.addr == `QPD_ISC_OFS) |=> ris_q.index)
		else $error("index status dropped without clear");
	a_irq_masked_only: assert property (inten_q == 0 |-> !irq) // [RULE10]
		else $error("irq with all sources disabled");
	// index, counting, velocity window and interrupt checks, seen from the registers
	a_index_fwd_zero: assert property (idx_rise && cfg_q.idx_reset && !rev_q && !pos_wr |=> pos_q == 0) // [RULE2]
		else $error("forward index did not clear position");
	a_one_count_step: assert property (step && fwd && !pos_wr && !(idx_rise && cfg_q.idx_reset) && // [RULE18]
		pos_q != max_q |=> pos_q == $past(pos_q) + 32'h00000001)
		else $error("forward step did not count exactly once");
	a_vel_save_clear: assert property (vel_run && tmr_q == 0 |=> cnt_q == 0 && spd_q == $past(cnt_q) + $past(vpulse)) // [RULE14]
		else $error("velocity window not saved and cleared");
	a_timer_irq_set: assert property (vel_run && tmr_q == 0 |=> ris_q.timer) // [RULE9]
		else $error("timer status not raised at expiry");
	a_irq_enabled_pend: assert property (ris_q.dir && inten_q.dir |-> irq) // [RULE10]
		else $error("enabled pending source did not raise irq");
endmodule

// file: design/qpd_map.svh
`ifndef QPD_MAP_SVH
`define QPD_MAP_SVH
// register byte offsets, low eight address bits
`define QPD_CTRL_OFS 8'h00
`define QPD_STAT_OFS 8'h04
`define QPD_POS_OFS 8'h08
`define QPD_MAXPOS_OFS 8'h0C
`define QPD_PERIOD_OFS 8'h10
`define QPD_TIMER_OFS 8'h14
`define QPD_COUNT_OFS 8'h18
`define QPD_SPEED_OFS 8'h1C
`define QPD_INTEN_OFS 8'h20
`define QPD_RIS_OFS 8'h24
`define QPD_ISC_OFS 8'h28
// control field positions
`define QPD_CTRL_EN 0
`define QPD_CTRL_BOTH 1
`define QPD_CTRL_IDXRST 2
`define QPD_CTRL_CLKDIR 3
`define QPD_CTRL_SWAP 4
`define QPD_CTRL_VELEN 5
`define QPD_CTRL_PDIV_LO 6
`define QPD_CTRL_PDIV_HI 8
// status field positions
`define QPD_STAT_ERR 0
`define QPD_STAT_REV 1
// reset values and interrupt source width
`define QPD_CTRL_RST 9'h000
`define QPD_MAXPOS_RST 32'hFFFFFFFF
`define QPD_PERIOD_RST 32'h0000C350
`define QPD_IRQ_W 4
`endif

// file: design/qpd_pkg.sv
package qpd_pkg;
	// control word, bit 0 is the module enable
	typedef struct packed {
		logic [2:0] prediv;
		logic vel_en;
		logic swap;
		logic clk_dir;
		logic idx_reset;
		logic both_edges;
		logic enable;
	} cfg_t;
	// interrupt sources, phase error in bit 0
	typedef struct packed {
		logic index;
		logic timer;
		logic dir;
		logic error;
	} irq_t;
	// latched address phase
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
	} ahb_req_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_CAPT = 2'b01,
		RD_SHOW = 2'b10
	} rd_state_t;
endpackage

// file: testbench/encoder_model.sv
`timescale 1ns/1ps
// rotary encoder with index; pins move just after a rising edge, phases held 8 cycles, index high for 4
module encoder_model (
	input wire logic hclk, // system clock
	output logic pin_first, // first phase
	output logic pin_second, // second phase
	output logic pin_index // index pulse
);
	// push-pull outputs, start low
	initial begin
		pin_first = 1'b0;
		pin_second = 1'b0;
		pin_index = 1'b0;
	end
	// one quadrature step, a single phase changes
	task automatic step(input logic rev);
		@(posedge hclk);
		if ((pin_first == pin_second) ^ rev) begin
			pin_first <= ~pin_first;
		end else begin
			pin_second <= ~pin_second;
		end
		repeat (8) @(posedge hclk);
	endtask
	// raw levels; both at once breaks the one-phase order on purpose
	task automatic pins(input logic a, input logic b);
		@(posedge hclk);
		pin_first <= a;
		pin_second <= b;
		repeat (8) @(posedge hclk);
	endtask
	// index pulse long enough for the synchroniser
	task automatic index_pulse;
		@(posedge hclk);
		pin_index <= 1'b1;
		repeat (4) @(posedge hclk);
		pin_index <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
`include "qpd_map.svh"
module tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, p1, p2, pidx;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	int err_total, tests_run;
	quadrature_position_decoder quadrature_position_decoder_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase_input_first(p1),
		.phase_input_second(p2), .index_input(pidx), .irq(irq));
	encoder_model encoder_model_inst (.hclk(hclk), .pin_first(p1), .pin_second(p2), .pin_index(pidx));
	// free-running 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(q, exp);
	endtask
	task automatic t_reset;
		rd(`QPD_CTRL_OFS, 32'h00000000);
		rd(`QPD_MAXPOS_OFS, 32'hFFFFFFFF);
		rd(`QPD_PERIOD_OFS, 32'h0000C350);
		rd(8'h2C, 32'h00000000); // unmapped offset reads zero
		chk({31'h0, irq}, 32'h00000000);
		chk({31'h0, hresp}, 32'h00000000); // bus response stays okay
		$display("test reset done");
	endtask
	// small maximum so both wraps are reached quickly
	task automatic t_wrap;
		wr(`QPD_MAXPOS_OFS, 32'h00000003);
		wr(`QPD_CTRL_OFS, 32'h00000003);
		for (int i = 1; i <= 4; i++) begin
			encoder_model_inst.step(1'b0);
			rd(`QPD_POS_OFS, 32'(i % 4));
		end
		rd(`QPD_STAT_OFS, 32'h00000000);
		encoder_model_inst.step(1'b1);
		rd(`QPD_POS_OFS, 32'h00000003);
		rd(`QPD_STAT_OFS, 32'h00000002);
		rd(`QPD_RIS_OFS, 32'h00000002);
		$display("test wrap done");
	endtask
	task automatic t_possw;
		wr(`QPD_POS_OFS, 32'h00000001);
		encoder_model_inst.step(1'b0);
		rd(`QPD_POS_OFS, 32'h00000002);
		rd(`QPD_STAT_OFS, 32'h00000000);
		encoder_model_inst.index_pulse();
		rd(`QPD_POS_OFS, 32'h00000002);
		$display("test position write done");
	endtask
	task automatic t_err;
		encoder_model_inst.pins(1'b1, 1'b1);
		rd(`QPD_STAT_OFS, 32'h00000001);
		rd(`QPD_POS_OFS, 32'h00000002);
		rd(`QPD_RIS_OFS, 32'h0000000B);
		$display("test phase error done");
	endtask
	// only the direction source enabled; masked view must hide the rest
	task automatic t_irq;
		chk({31'h0, irq}, 32'h00000000);
		wr(`QPD_INTEN_OFS, 32'h00000002);
		rd(`QPD_ISC_OFS, 32'h00000002);
		chk({31'h0, irq}, 32'h00000001);
		wr(`QPD_RIS_OFS, 32'h00000002);
		rd(`QPD_RIS_OFS, 32'h00000009);
		chk({31'h0, irq}, 32'h00000000);
		wr(`QPD_RIS_OFS, 32'h00000009);
		wr(`QPD_STAT_OFS, 32'h00000001);
		rd(`QPD_STAT_OFS, 32'h00000000);
		rd(`QPD_RIS_OFS, 32'h00000000);
		$display("test interrupts done");
	endtask
	task automatic t_index;
		wr(`QPD_CTRL_OFS, 32'h00000007);
		encoder_model_inst.index_pulse();
		rd(`QPD_POS_OFS, 32'h00000000);
		rd(`QPD_RIS_OFS, 32'h00000008);
		wr(`QPD_POS_OFS, 32'h00000002);
		encoder_model_inst.step(1'b1);
		rd(`QPD_POS_OFS, 32'h00000001);
		encoder_model_inst.index_pulse();
		rd(`QPD_POS_OFS, 32'h00000003);
		$display("test index done");
	endtask
	// first-phase-only counting, then step clock plus direction, then swapped
	task automatic t_modes;
		wr(`QPD_CTRL_OFS, 32'h00000001);
		encoder_model_inst.step(1'b0);
		rd(`QPD_POS_OFS, 32'h00000003);
		encoder_model_inst.step(1'b0);
		rd(`QPD_POS_OFS, 32'h00000000);
		wr(`QPD_CTRL_OFS, 32'h00000009);
		encoder_model_inst.pins(1'b0, 1'b0);
		encoder_model_inst.pins(1'b1, 1'b0);
		rd(`QPD_POS_OFS, 32'h00000001);
		encoder_model_inst.pins(1'b0, 1'b1);
		encoder_model_inst.pins(1'b1, 1'b1);
		rd(`QPD_POS_OFS, 32'h00000000);
		wr(`QPD_CTRL_OFS, 32'h00000019);
		encoder_model_inst.pins(1'b1, 1'b0);
		encoder_model_inst.pins(1'b0, 1'b0);
		encoder_model_inst.pins(1'b0, 1'b1);
		rd(`QPD_POS_OFS, 32'h00000001);
		$display("test modes done");
	endtask
	task automatic t_off;
		wr(`QPD_CTRL_OFS, 32'h00000000);
		encoder_model_inst.step(1'b0);
		rd(`QPD_POS_OFS, 32'h00000001);
		wr(`QPD_CTRL_OFS, 32'h00000020);
		encoder_model_inst.step(1'b0);
		rd(`QPD_TIMER_OFS, 32'h0000C350);
		rd(`QPD_COUNT_OFS, 32'h00000000);
		$display("test disable done");
	endtask
	// poll the raw timer status until it rises, then clear it for the next window
	task automatic wait_tick;
		int n;
		n = 0;
		do begin
			bus(1'b0, `QPD_RIS_OFS, 32'h00000000);
			n++;
		end while (q[2] !== 1'b1 && n < 30000);
		chk({31'h0, q[2]}, 32'h00000001);
		wr(`QPD_RIS_OFS, 32'h00000004);
	endtask
	// first window runs from the reset timer value; later ones use the short period
	task automatic t_vel;
		wr(`QPD_PERIOD_OFS, 32'h00000100);
		wr(`QPD_CTRL_OFS, 32'h00000023);
		repeat (3) encoder_model_inst.step(1'b0);
		rd(`QPD_COUNT_OFS, 32'h00000003);
		wait_tick();
		rd(`QPD_SPEED_OFS, 32'h00000003);
		rd(`QPD_COUNT_OFS, 32'h00000000);
		// predivide by two: four steps land in one short window as two pulses
		wr(`QPD_CTRL_OFS, 32'h00000063);
		repeat (4) encoder_model_inst.step(1'b0);
		wait_tick();
		rd(`QPD_SPEED_OFS, 32'h00000002);
		$display("test velocity done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// hang guard, about twice the expected run
	initial begin
		repeat (100000) @(posedge hclk);
		err_total++;
		wrap_up();
	end
	initial begin
		err_total = 0;
		tests_run = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'h2;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_wrap();
		t_possw();
		t_err();
		t_irq();
		t_index();
		t_modes();
		t_off();
		t_vel();
		wrap_up();
	end
endmodule
